// File: rtl/smis_cfg.svh
// Offsets, field positions and reset values of the masked event status block
`ifndef SMIS_CFG_SVH
`define SMIS_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SMIS_OFF_BROWNOUT_CTRL   12'h030
`define SMIS_OFF_RAW_STATUS      12'h050
`define SMIS_OFF_MASK_ENABLE     12'h054
`define SMIS_OFF_MASKED_CLEAR    12'h058

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define SMIS_EVT_COUNT           7
`define SMIS_BIT_PLL_LOCK        6
`define SMIS_BIT_CURRENT_LIMIT   5
`define SMIS_BIT_INT_OSC_FAULT   4
`define SMIS_BIT_MAIN_OSC_FAULT  3
`define SMIS_BIT_REG_UNREG       2
`define SMIS_BIT_BROWNOUT        1
`define SMIS_BIT_PLL_FAULT       0
`define SMIS_BIT_BO_RESET_SEL    1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SMIS_RST_EVT             7'h00
`define SMIS_RST_WORD            32'h0000_0000
`define SMIS_RST_BIT             1'b0

`endif

// File: rtl/smis_pkg.sv
// Types shared by the masked event status block and its bench
package smis_pkg;

   // ----------------------------------------------------------------------------
   // Register bus request carried as one bundle
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wrData;
      logic        wrStb;
      logic        rdStb;
   } smis_bus_req_t;

   // Seven event lines, bit order as in the masked status word
   typedef logic [6:0] smis_evt_t;

endpackage

// File: rtl/smis_masked_status.sv
// Masked event status and clear register with raw flags, mask and interrupt
`include "smis_cfg.svh"

module smis_masked_status
   import smis_pkg::*;
#(
   parameter int NUM_EVT = `SMIS_EVT_COUNT
) (
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire smis_bus_req_t busReq,
   input  wire smis_evt_t     eventIn,
   output logic [31:0]        rdData_q,
   output logic               sysIrq_q
);

   // ----------------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------------
   if (NUM_EVT != `SMIS_EVT_COUNT) begin : g_chk
      $error("smis_masked_status serves exactly seven event bits");
   end

   // ----------------------------------------------------------------------------
   // State and next values
   // ----------------------------------------------------------------------------
   smis_evt_t rawFlag_q;
   smis_evt_t rawFlag_d;
   smis_evt_t maskEn_q;
   smis_evt_t maskEn_d;
   logic      boResetSel_q;
   logic      boResetSel_d;
   smis_evt_t clearMask;
   smis_evt_t maskedNow;
   logic      wrMasked;

   // Masked view of the raw flags; brown-out also gated by reset select
   function automatic smis_evt_t maskedOf(input smis_evt_t raw, input smis_evt_t msk,
                                          input logic boSel);
      smis_evt_t m;
      m = raw & msk;
      m[`SMIS_BIT_BROWNOUT] = m[`SMIS_BIT_BROWNOUT] & ~boSel;
      return m;
   endfunction

   // Address match for a strobe
   function automatic logic hit(input smis_bus_req_t r, input logic [11:0] off);
      return r.addr == off;
   endfunction

   // ----------------------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------------------
   // Ones written to the masked register pick bits to clear
   assign wrMasked  = busReq.wrStb && hit(busReq, `SMIS_OFF_MASKED_CLEAR);
   assign clearMask = wrMasked ? busReq.wrData[NUM_EVT-1:0] : `SMIS_RST_EVT;
   assign maskedNow = maskedOf(rawFlag_q, maskEn_q, boResetSel_q);

   // Raw flags: a new event wins over a clear in the same cycle
   always_comb begin
      rawFlag_d = (rawFlag_q & ~clearMask) | eventIn;
   end

   // Mask enable register, written whole
   always_comb begin
      maskEn_d = maskEn_q;
      if (busReq.wrStb && hit(busReq, `SMIS_OFF_MASK_ENABLE)) begin
         maskEn_d = busReq.wrData[NUM_EVT-1:0];
      end
   end

   // Brown-out reset versus interrupt select bit
   always_comb begin
      boResetSel_d = boResetSel_q;
      if (busReq.wrStb && hit(busReq, `SMIS_OFF_BROWNOUT_CTRL)) begin
         boResetSel_d = busReq.wrData[`SMIS_BIT_BO_RESET_SEL];
      end
   end

   // ----------------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------------
   // Raw event flags
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rawFlag_q <= `SMIS_RST_EVT;
      end else begin
         rawFlag_q <= rawFlag_d;
      end
   end

   // Mask enables and brown-out select
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         maskEn_q     <= `SMIS_RST_EVT;
         boResetSel_q <= `SMIS_RST_BIT;
      end else begin
         maskEn_q     <= maskEn_d;
         boResetSel_q <= boResetSel_d;
      end
   end

   // Interrupt level follows the masked bits of the same state
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sysIrq_q <= `SMIS_RST_BIT;
      end else begin
         sysIrq_q <= |maskedOf(rawFlag_d, maskEn_d, boResetSel_d);
      end
   end

   // ----------------------------------------------------------------------------
   // Read port: data one cycle after the strobe, zero otherwise
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdData_q <= `SMIS_RST_WORD;
      end else begin
         rdData_q <= `SMIS_RST_WORD;   // Unmapped and reserved bits read zero
         if (busReq.rdStb) begin
            unique case (busReq.addr)
               `SMIS_OFF_MASKED_CLEAR:
                  rdData_q[NUM_EVT-1:0] <= maskedNow;
               `SMIS_OFF_RAW_STATUS:
                  rdData_q[NUM_EVT-1:0] <= rawFlag_q;
               `SMIS_OFF_MASK_ENABLE:
                  rdData_q[NUM_EVT-1:0] <= maskEn_q;
               `SMIS_OFF_BROWNOUT_CTRL:
                  rdData_q[`SMIS_BIT_BO_RESET_SEL] <= boResetSel_q;
               default:
                  rdData_q <= `SMIS_RST_WORD;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cbSys @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // Write of ones to the masked register with no fresh event
   sequence sClearAll;
      wrMasked && (busReq.wrData[NUM_EVT-1:0] == 7'h7F) && (eventIn == `SMIS_RST_EVT);
   endsequence

   // Read of the masked register
   sequence sReadMasked;
      busReq.rdStb && (busReq.addr == `SMIS_OFF_MASKED_CLEAR);
   endsequence

   // Interrupt agrees with the masked bits
   a_irq_tracks_masked: assert property (
      ##1 (sysIrq_q == |maskedNow))
      else $error("interrupt differs from masked status");

   // Writing ones leaves nothing pending next cycle
   a_clear_masked_bits: assert property (
      sClearAll |=> (maskedNow == `SMIS_RST_EVT) && !sysIrq_q)
      else $error("masked bits not cleared by write of ones");

   // Writing ones clears the raw flags too
   a_clear_raw_flags: assert property (
      sClearAll |=> (rawFlag_q == `SMIS_RST_EVT))
      else $error("raw flags not cleared with masked bits");

   // Writing zero to a bit leaves it set
   a_zero_write_keeps: assert property (
      (wrMasked && !busReq.wrData[`SMIS_BIT_PLL_FAULT] && rawFlag_q[`SMIS_BIT_PLL_FAULT])
      |=> rawFlag_q[`SMIS_BIT_PLL_FAULT])
      else $error("zero write disturbed a status bit");

   // Masked register reads back with upper bits zero
   a_read_masked_word: assert property (
      sReadMasked |=> (rdData_q == {25'h0, $past(maskedNow)}))
      else $error("masked register read wrong");

   // PLL lock event sets its masked bit when enabled and not cleared
   a_pll_lock_sets: assert property (
      (eventIn[`SMIS_BIT_PLL_LOCK] && maskEn_d[`SMIS_BIT_PLL_LOCK])
      |=> maskedNow[`SMIS_BIT_PLL_LOCK] ##0 sysIrq_q)
      else $error("PLL lock event lost");

   // All masks clear for two cycles keep the interrupt low
   a_mask_blocks_irq: assert property (
      (maskEn_q == `SMIS_RST_EVT) [*2] |-> !sysIrq_q)
      else $error("interrupt raised with all masks clear");

   // Brown-out selected for reset never shows as masked
   a_brownout_select: assert property (
      boResetSel_q |-> !maskedNow[`SMIS_BIT_BROWNOUT])
      else $error("brown-out masked while reset is selected");

   // Read data falls back to zero outside the answer cycle
   a_read_idle_zero: assert property (
      !busReq.rdStb |=> (rdData_q == `SMIS_RST_WORD))
      else $error("read data not zero outside read cycle");

   // A fresh event beats a clear of the same bit
   a_event_beats_clear: assert property (
      (clearMask[`SMIS_BIT_PLL_FAULT] && eventIn[`SMIS_BIT_PLL_FAULT])
      |=> rawFlag_q[`SMIS_BIT_PLL_FAULT])
      else $error("event lost against a clear in the same cycle");

   // A raw flag stays set until a one is written to it
   a_raw_flag_sticky: assert property (
      (rawFlag_q[`SMIS_BIT_PLL_LOCK] && !clearMask[`SMIS_BIT_PLL_LOCK])
      |=> rawFlag_q[`SMIS_BIT_PLL_LOCK])
      else $error("raw flag dropped without a clear");

   // A write to the mask register lands whole
   a_mask_write_lands: assert property (
      (busReq.wrStb && hit(busReq, `SMIS_OFF_MASK_ENABLE))
      |=> (maskEn_q == $past(busReq.wrData[NUM_EVT-1:0])))
      else $error("mask enable write did not land");

endmodule

// File: test/smis_masked_status_tb_top.sv
// Self-checking bench for the masked event status and clear register
module smis_masked_status_tb_top
   import smis_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------------------
   // Stimulus, reference state and counters
   // ----------------------------------------------------------------------------
   logic          clk_sys = 1'b0;
   logic          rst     = 1'b1;
   smis_bus_req_t busReq  = '0;
   smis_evt_t     eventIn = 7'h00;
   logic [31:0]   rdData_q;
   logic          sysIrq_q;
   int            mRaw, mMask, mSel;
   int            bad_count   = 0;
   int            check_count = 0;
   int            cycles      = 0;
   logic [31:0]   clr;

   always #5 clk_sys = ~clk_sys;

   smis_masked_status smis_masked_status_i (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .busReq   (busReq),
      .eventIn  (eventIn),
      .rdData_q (rdData_q),
      .sysIrq_q (sysIrq_q)
   );

   // Masked view: raw AND mask, brown-out also blocked by its reset select
   function automatic int mskd();
      mskd = mRaw & mMask & (mSel ? 32'h7D : 32'h7F);
   endfunction

   // Reference model, sampled at the same edge as the design
   always @(posedge clk_sys) begin
      cycles++;
      if (rst) begin
         mRaw = 0; mMask = 0; mSel = 0;
      end else begin
         if (busReq.wrStb && busReq.addr == 12'h058) mRaw &= ~int'(busReq.wrData[6:0]);
         if (busReq.wrStb && busReq.addr == 12'h054) mMask = int'(busReq.wrData[6:0]);
         if (busReq.wrStb && busReq.addr == 12'h030) mSel = int'(busReq.wrData[1]);
         mRaw |= int'(eventIn);
      end
      if (cycles > 5000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Interrupt level follows the masked bits every cycle
   always @(negedge clk_sys) chk({31'h0, sysIrq_q}, {31'h0, mskd() != 0});

   // One bus cycle, with an event pattern presented in the same cycle
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input smis_evt_t ev, input int exp);
      @(posedge clk_sys);
      busReq  <= '{a, d, w, ~w};
      eventIn <= ev;
      @(posedge clk_sys);
      busReq  <= '{a, d, 1'b0, 1'b0};
      eventIn <= 7'h00;
      #1;
      if (!w) chk(rdData_q, exp[31:0]);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------------
   initial begin
      void'($urandom(32'hc010));
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      bus(1'b0, 12'h058, 32'h0, 7'h00, 0);
      bus(1'b0, 12'h0FC, 32'h0, 7'h00, 0);
      // Masked event with PLL lock alone, then cleared by a one
      bus(1'b1, 12'h054, 32'h40, 7'h40, 0);
      bus(1'b0, 12'h058, 32'h0, 7'h00, 32'h40);
      bus(1'b1, 12'h058, 32'h0, 7'h00, 0);
      bus(1'b0, 12'h058, 32'h0, 7'h00, 32'h40);
      bus(1'b1, 12'h058, 32'hFFFF_FFC0, 7'h00, 0);
      bus(1'b0, 12'h058, 32'h0, 7'h00, 0);
      // All events pending, then one write of ones clears every flag
      bus(1'b1, 12'h054, 32'h7F, 7'h7F, 0);
      bus(1'b0, 12'h058, 32'h0, 7'h00, 32'h7F);
      bus(1'b1, 12'h058, 32'hFFFF_FFFF, 7'h00, 0);
      bus(1'b0, 12'h050, 32'h0, 7'h00, 0);
      bus(1'b0, 12'h058, 32'h0, 7'h00, 0);
      for (int i = 0; i < 40; i++) begin
         bus(1'b1, 12'h054, $urandom, 7'h00, 0);
         bus(1'b1, 12'h030, $urandom, 7'h00, 0);
         bus(1'b0, 12'h058, 32'h0, 7'($urandom), mskd());
         bus(1'b0, 12'h058, 32'h0, 7'h00, mskd());
         bus(1'b0, 12'h050, 32'h0, 7'h00, mRaw);
         clr = $urandom & mskd();
         clr[31:7] = 25'h0;
         bus(1'b1, 12'h058, clr, (i % 4 == 0) ? 7'($urandom) : 7'h00, 0);
         bus(1'b0, 12'h058, 32'h0, 7'h00, mskd());
         bus(1'b0, 12'h050, 32'h0, 7'h00, mRaw);
      end
      end_of_test();
   end

endmodule
